/* File: hdl/prom_prog_pkg.sv */
package prom_prog_pkg;

  // Address and data widths and page size of the programming port
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 4;
  // Bottom and top of the programmable range
  localparam logic [16:0] ADDR_FIRST = 17'h0_0000;
  localparam logic [16:0] ADDR_LAST = 17'h0_EFFF;
  // Retry ceiling per byte job or per whole page
  localparam logic [3:0] MAX_TRIES = 4'hA;
  // Clock and timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int PULSE_NS = 100000;
  localparam int PULSE_CYC = (PULSE_NS * 1000) / CLK_PERIOD_PS;
  localparam int SETUP_NS = 1000;
  localparam int SETUP_CYC = (SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACCESS_NS = 200;
  localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Supply level requests
  typedef enum logic [1:0] {
    SUP_OFF,
    SUP_READ,
    SUP_PROG
  } supply_e;

  // Operation requested by the user side
  typedef enum logic [1:0] {
    OP_READ,
    OP_BYTE,
    OP_PAGE
  } op_e;

  // A command word
  typedef struct packed {
    op_e op;
    logic [16:0] addr;
    logic [16:0] last;
    logic [31:0] data;
  } cmd_s;

  // A result word
  typedef struct packed {
    logic [16:0] addr;
    logic [7:0] data;
    logic fail;
  } res_s;

endpackage

/* File: hdl/skid_buffer.sv */
`timescale 1ns/100ps
// Two-entry buffer so the result path never drops a word
module skid_buffer
  import prom_prog_pkg::*;
#(
  parameter int WIDTH = 26,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  // Only the two-entry form is built; one pointer bit per side
  if (DEPTH != 2 || WIDTH < 1) begin : g_bad_shape
    $error("skid_buffer supports depth 2 only");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic wrPtr;
  logic rdPtr;
  logic [1:0] count;
  wire doWrite = inValid && inReady;
  wire doRead = outValid && outReady;

  // Full and empty follow the occupancy count
  assign inReady = (count != 2'd2);
  assign outValid = (count != 2'd0);
  assign outData = mem[rdPtr];

  // Pointer and count upkeep
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'd0;
    end else begin
      wrPtr <= wrPtr ^ doWrite;
      rdPtr <= rdPtr ^ doRead;
      count <= count + {1'b0, doWrite} - {1'b0, doRead};
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule // skid_buffer

/* File: hdl/prom_programmer.sv */
`timescale 1ns/100ps
// Function
// [RULE1] Supply raised, reset low before access
// [RULE2] Enable and output low reads byte
// [RULE3] Output strobe high floats data lines
// [RULE4] Enable high means standby, data floats
// [RULE5] Enable, program high, output low latch
// [RULE6] Page written by one timed pulse
// [RULE7] Byte written with enable low pulse
// [RULE8] Verify read after each write
// [RULE9] Retry write and verify, ten maximum
// [RULE10] Program strobe high inhibits write
// [RULE11] Write only addresses zero to top
// [RULE12] Advance address after verified location
// [RULE13] Final full verify at read supply
// [RULE14] Read: reset low, address, then strobes
// [RULE15] Main supply first on, last off
// [RULE16] Program strobe selects write or inhibit
module prom_programmer
  import prom_prog_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC,
  parameter int RESULT_DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire cmd_s cmd,
  output logic resValid,
  input wire logic resReady,
  output res_s res,
  output logic busy,
  output logic mainSupplyOn,
  output logic progSupplyOn,
  output logic progSupplyHigh,
  output logic partReset_n,
  output logic [16:0] prog_address_inputs,
  output logic [7:0] prog_data_lines_out,
  output logic prog_data_lines_oe_n,
  input wire logic [7:0] prog_data_lines_in,
  output logic enable_n,
  output logic output_n,
  output logic program_pulse_n
);
  // The step timer is sixteen bits wide
  if (PULSE_CYCLES < 1 || PULSE_CYCLES > 65535) begin : g_bad_pulse
    $error("PULSE_CYCLES must fit the step timer");
  end
  if (RESULT_DEPTH != 2) begin : g_bad_depth
    $error("RESULT_DEPTH must be 2");
  end

  typedef enum {
    S_IDLE, S_MAIN_ON, S_VPP_ON, S_LATCH, S_LATCH_END, S_PULSE, S_PULSE_END,
    S_VERIFY, S_CHECK, S_NEXT, S_FINAL_SUP, S_FINAL_RD, S_FINAL_CHK, S_EMIT,
    S_VPP_OFF, S_MAIN_OFF
  } state_e;

  state_e state;
  cmd_s job;
  logic [16:0] addr;
  logic [16:0] pageBase;
  logic [1:0] pageIdx;
  logic [3:0] tries;
  logic [15:0] timer;
  logic [7:0] sample;
  logic failed;
  logic finalPass;
  logic bufReady;
  res_s resIn;

  // Helper terms for decoding the job
  wire isPage = (job.op == OP_PAGE);
  wire isRead = (job.op == OP_READ);
  wire timerDone = (timer == 16'h0000);
  wire [7:0] expected = job.data[8*pageIdx +: 8];
  wire [16:0] lastAddr = (job.last > ADDR_LAST) ? ADDR_LAST : job.last; // [RULE11]
  wire atLast = (addr >= lastAddr);
  wire pageFull = (pageIdx == 2'd3);
  // Byte and read jobs end after one location, pages at their end
  wire lastOfJob = atLast || pageFull || !isPage;
  // Judge the incoming word, not the job still held from before
  wire cmdOk = (cmd.op == OP_READ) || (cmd.addr <= ADDR_LAST); // [RULE11]
  // A refused job never powers or selects the part
  wire jobOk = isRead || (job.addr <= ADDR_LAST); // [RULE11]

  assign cmdReady = (state == S_IDLE);
  assign busy = (state != S_IDLE);

  // Main sequencer; every step waits on the timer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      job <= '0;
      addr <= 17'h0_0000;
      pageBase <= 17'h0_0000;
      pageIdx <= 2'd0;
      tries <= 4'h0;
      timer <= 16'h0000;
      sample <= 8'h00;
      failed <= 1'b0;
      finalPass <= 1'b0;
    end else begin
      if (!timerDone) begin
        timer <= timer - 16'h0001;
      end else begin
        case (state)
          S_IDLE: begin
            if (cmdValid) begin
              job <= cmd;
              addr <= cmd.addr;
              pageBase <= cmd.addr;
              pageIdx <= 2'd0;
              tries <= 4'h0;
              failed <= !cmdOk;
              finalPass <= 1'b0;
              state <= cmdOk ? S_MAIN_ON : S_EMIT;
              timer <= 16'(SETUP_CYC);
            end
          end
          S_MAIN_ON: begin // [RULE15]
            state <= S_VPP_ON;
            timer <= 16'(SETUP_CYC);
          end
          S_VPP_ON: begin // [RULE1]
            state <= isRead ? S_FINAL_RD : (isPage ? S_LATCH : S_PULSE);
            timer <= (isPage || isRead) ? 16'(ACCESS_CYC) : 16'(PULSE_CYCLES);
            if (!isPage && !isRead) begin
              tries <= tries + 4'h1;
            end
          end
          S_LATCH: begin // [RULE5]
            state <= S_LATCH_END;
            timer <= 16'(SETUP_CYC);
          end
          S_LATCH_END: begin
            if (pageFull || atLast) begin
              state <= S_PULSE;
              timer <= 16'(PULSE_CYCLES);
              tries <= tries + 4'h1;
            end else begin
              addr <= addr + 17'h0_0001;
              pageIdx <= pageIdx + 2'd1;
              state <= S_LATCH;
              timer <= 16'(ACCESS_CYC);
            end
          end
          S_PULSE: begin // [RULE6] [RULE7]
            state <= S_PULSE_END;
            timer <= 16'(SETUP_CYC);
            if (isPage) begin
              addr <= pageBase;
              pageIdx <= 2'd0;
            end
          end
          S_PULSE_END: begin
            state <= S_VERIFY;
            timer <= 16'(ACCESS_CYC);
          end
          S_VERIFY: begin // [RULE8]
            sample <= prog_data_lines_in;
            state <= S_CHECK;
          end
          S_CHECK: begin
            if (sample != expected) begin
              if (tries == MAX_TRIES) begin // [RULE9]
                failed <= 1'b1;
                state <= S_FINAL_SUP;
              end else begin
                addr <= pageBase;
                pageIdx <= 2'd0;
                state <= isPage ? S_LATCH : S_PULSE;
                timer <= isPage ? 16'(ACCESS_CYC) : 16'(PULSE_CYCLES);
                tries <= isPage ? tries : tries + 4'h1;
              end
            end else begin
              state <= S_NEXT;
            end
          end
          S_NEXT: begin // [RULE12]
            if (lastOfJob) begin
              state <= S_FINAL_SUP;
              timer <= 16'(SETUP_CYC);
            end else begin
              addr <= addr + 17'h0_0001;
              pageIdx <= pageIdx + 2'd1;
              state <= S_VERIFY;
              timer <= 16'(ACCESS_CYC);
            end
          end
          S_FINAL_SUP: begin // [RULE13]
            addr <= job.addr;
            pageIdx <= 2'd0;
            finalPass <= 1'b1;
            state <= S_FINAL_RD;
            timer <= 16'(ACCESS_CYC);
          end
          S_FINAL_RD: begin // [RULE14]
            sample <= prog_data_lines_in;
            state <= isRead ? S_EMIT : S_FINAL_CHK;
          end
          S_FINAL_CHK: begin
            if (sample != expected) begin
              failed <= 1'b1;
            end
            if (lastOfJob) begin
              state <= S_EMIT;
            end else begin
              addr <= addr + 17'h0_0001;
              pageIdx <= pageIdx + 2'd1;
              state <= S_FINAL_RD;
              timer <= 16'(ACCESS_CYC);
            end
          end
          S_EMIT: begin
            if (bufReady) begin
              state <= jobOk ? S_VPP_OFF : S_IDLE;
              timer <= jobOk ? 16'(SETUP_CYC) : 16'h0000;
            end
          end
          S_VPP_OFF: begin // [RULE15]
            state <= S_MAIN_OFF;
            timer <= 16'(SETUP_CYC);
          end
          S_MAIN_OFF: begin
            state <= S_IDLE;
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // Pin drive decode from state
  wire inLatch = (state == S_LATCH) || (state == S_LATCH_END);
  wire inPulse = (state == S_PULSE);
  wire inRead = (state == S_VERIFY) || (state == S_FINAL_RD) || (state == S_CHECK);
  wire inWriteWin = inLatch || inPulse || (state == S_PULSE_END);
  wire suppliesUp = jobOk && (state != S_IDLE) && (state != S_MAIN_OFF)
    && (state != S_MAIN_ON);
  wire mainUp = jobOk && (((state != S_IDLE) && (state != S_MAIN_OFF))
    || ((state == S_MAIN_OFF) && !timerDone));
  wire highLevel = !isRead && !finalPass && suppliesUp && (state != S_VPP_OFF)
    && (state != S_EMIT);

  // Registered pin outputs keep glitches off the strobes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mainSupplyOn <= 1'b0;
      progSupplyOn <= 1'b0;
      progSupplyHigh <= 1'b0;
      partReset_n <= 1'b1;
      prog_address_inputs <= 17'h0_0000;
      prog_data_lines_out <= 8'h00;
      prog_data_lines_oe_n <= 1'b1;
      enable_n <= 1'b1;
      output_n <= 1'b1;
      program_pulse_n <= 1'b1;
    end else begin
      mainSupplyOn <= mainUp; // [RULE15]
      progSupplyOn <= suppliesUp && (state != S_VPP_OFF); // [RULE1]
      progSupplyHigh <= highLevel;
      partReset_n <= (state == S_IDLE) || !jobOk; // [RULE1]
      prog_address_inputs <= addr; // [RULE14]
      prog_data_lines_out <= expected;
      prog_data_lines_oe_n <= !((inLatch && isPage) || (inPulse && !isPage)); // [RULE3]
      enable_n <= !(inRead || (inPulse && !isPage) || (inWriteWin && !isPage)); // [RULE4]
      output_n <= !(inRead || inLatch); // [RULE2] [RULE5]
      program_pulse_n <= !(inPulse && timerDone == 1'b0); // [RULE10] [RULE16]
    end
  end

  // Result word formed from the tracked state
  assign resIn = '{addr: job.addr, data: sample, fail: failed};

  // Results pass a two-entry buffer so a slow reader loses nothing
  skid_buffer #(
    .WIDTH($bits(res_s)),
    .DEPTH(RESULT_DEPTH)
  ) resultBuf (
    .clk(clk),
    .rst_n(rst_n),
    .inValid((state == S_EMIT) && timerDone),
    .inReady(bufReady),
    .inData(resIn),
    .outValid(resValid),
    .outReady(resReady),
    .outData(res)
  );
endmodule // prom_programmer

/* File: verif/prom_programmer_properties.sv */
`timescale 1ns/100ps
// Port-level checks of the programmer, one clock domain
module prom_programmer_properties
  import prom_prog_pkg::*;
#(
  parameter int PULSE_CYCLES = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire cmd_s cmd,
  input wire logic resValid,
  input wire logic resReady,
  input wire res_s res,
  input wire logic mainSupplyOn,
  input wire logic progSupplyOn,
  input wire logic progSupplyHigh,
  input wire logic partReset_n,
  input wire logic [16:0] prog_address_inputs,
  input wire logic prog_data_lines_oe_n,
  input wire logic enable_n,
  input wire logic output_n,
  input wire logic program_pulse_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  int lowCnt;
  // Cycles the program pulse has been low so far
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lowCnt <= 0;
    else lowCnt <= program_pulse_n ? 0 : lowCnt + 1;
  end
  a_mode_before_strobe: assert property (!(enable_n && output_n && program_pulse_n) |->
    mainSupplyOn && progSupplyOn && !partReset_n) else $error("strobe outside mode");
  a_supply_order: assert property (progSupplyOn |-> mainSupplyOn)
    else $error("program supply without main supply");
  a_pulse_len: assert property ($rose(program_pulse_n) |-> lowCnt == PULSE_CYCLES)
    else $error("program pulse length wrong");
  a_pulse_level: assert property (!program_pulse_n |-> progSupplyHigh && output_n)
    else $error("pulse without high supply or with read strobe");
  a_release_on_read: assert property (!enable_n && !output_n |-> prog_data_lines_oe_n)
    else $error("controller drives data during read");
  a_pulse_range: assert property (!program_pulse_n |-> prog_address_inputs <= ADDR_LAST)
    else $error("write above top address");
  a_pulse_steady: assert property (!program_pulse_n && !$fell(program_pulse_n) |->
    $stable(prog_address_inputs) && $stable(enable_n)) else $error("pins moved in pulse");
  a_refuse_quiet: assert property (cmdValid && cmdReady && cmd.op != OP_READ &&
    cmd.addr > ADDR_LAST |=> !mainSupplyOn [*4]) else $error("refused write powered part");
  a_result_hold: assert property (resValid && !resReady |=> resValid && $stable(res))
    else $error("result dropped before taken");
  c_byte_pulse: cover property (!program_pulse_n && !enable_n);
  c_page_pulse: cover property (!program_pulse_n && enable_n);
  c_result_stall: cover property (resValid && !resReady);
endmodule // prom_programmer_properties

bind prom_programmer prom_programmer_properties #(.PULSE_CYCLES(PULSE_CYCLES))
  prom_programmer_properties_i (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid),
  .cmdReady(cmdReady), .cmd(cmd), .resValid(resValid), .resReady(resReady), .res(res),
  .mainSupplyOn(mainSupplyOn), .progSupplyOn(progSupplyOn), .progSupplyHigh(progSupplyHigh),
  .partReset_n(partReset_n), .prog_address_inputs(prog_address_inputs),
  .prog_data_lines_oe_n(prog_data_lines_oe_n), .enable_n(enable_n), .output_n(output_n),
  .program_pulse_n(program_pulse_n));

/* File: verif/otp_device_model.sv */
`timescale 1ns/100ps
// Behavioural one-time memory in programming mode; skip makes pulses fail
module otp_device_model (
  input wire logic clk,
  input wire logic mainSupplyOn,
  input wire logic progSupplyOn,
  input wire logic progSupplyHigh,
  input wire logic partReset_n,
  input wire logic [16:0] prog_address_inputs,
  input wire logic [7:0] busIn,
  input wire logic enable_n,
  input wire logic output_n,
  input wire logic program_pulse_n,
  input wire logic [3:0] skip,
  output logic [7:0] devData,
  output logic devDrive
);
  logic [7:0] mem [0:131071];
  logic [7:0] pageLatch [4];
  logic [3:0] pageFull = 4'h0;
  logic [16:0] pageAddr = 17'h0_0000;
  logic pulseSeen = 1'b0;
  int skipped = 0;
  wire inMode = mainSupplyOn && progSupplyOn && !partReset_n;
  // Selected and read strobe low only; else the lines float
  assign devDrive = inMode && !enable_n && !output_n;
  assign devData = mem[prog_address_inputs];
  // Erased cells read as all ones
  initial begin
    for (int i = 0; i < 131072; i++) mem[i] = 8'hFF;
  end
  // Writes act once per pulse; a part whose pulse stays high is untouched
  always @(posedge clk) begin
    if (partReset_n) skipped <= 0;
    if (inMode && enable_n && program_pulse_n && !output_n) begin
      pageLatch[prog_address_inputs[1:0]] <= busIn;
      pageFull[prog_address_inputs[1:0]] <= 1'b1;
      pageAddr <= {prog_address_inputs[16:2], 2'b00};
    end
    if (inMode && progSupplyHigh && !program_pulse_n && !pulseSeen) begin
      if (skipped < skip) skipped <= skipped + 1;
      else if (!enable_n && output_n) mem[prog_address_inputs] <= busIn;
      else if (enable_n && output_n) begin
        for (int i = 0; i < 4; i++) if (pageFull[i]) mem[pageAddr + i] <= pageLatch[i];
        pageFull <= 4'h0;
      end
    end
    pulseSeen <= !program_pulse_n;
  end
endmodule // otp_device_model

/* File: verif/prom_programmer_test.sv */
`timescale 1ns/100ps
module prom_programmer_test;
  import prom_prog_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmdValid = 1'b0;
  logic resReady = 1'b0;
  cmd_s cmd = '0;
  logic [3:0] skip = 4'h0;
  logic [7:0] lastBus = 8'h00;
  logic cmdReady, resValid, busy, mainSupplyOn, progSupplyOn, progSupplyHigh, partReset_n;
  logic dataOe_n, enable_n, output_n, program_pulse_n, devDrive;
  logic [16:0] addrPins;
  logic [7:0] dataOut, devData;
  res_s res;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  int pulses = 0;
  // A released bus shows a changing pattern, never a stale value
  wire [7:0] dataBus = !dataOe_n ? dataOut : devDrive ? devData : ~lastBus;
  always #12.5 clk = ~clk;
  always @(posedge clk) lastBus <= dataBus;
  always @(negedge program_pulse_n) pulses++;

  prom_programmer #(.PULSE_CYCLES(10)) prom_programmer_i (.clk(clk), .rst_n(rst_n),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd), .resValid(resValid),
    .resReady(resReady), .res(res), .busy(busy), .mainSupplyOn(mainSupplyOn),
    .progSupplyOn(progSupplyOn), .progSupplyHigh(progSupplyHigh), .partReset_n(partReset_n),
    .prog_address_inputs(addrPins), .prog_data_lines_out(dataOut),
    .prog_data_lines_oe_n(dataOe_n), .prog_data_lines_in(dataBus), .enable_n(enable_n),
    .output_n(output_n), .program_pulse_n(program_pulse_n));
  otp_device_model otp_device_model_i (.clk(clk), .mainSupplyOn(mainSupplyOn),
    .progSupplyOn(progSupplyOn), .progSupplyHigh(progSupplyHigh), .partReset_n(partReset_n),
    .prog_address_inputs(addrPins), .busIn(dataBus), .enable_n(enable_n),
    .output_n(output_n), .program_pulse_n(program_pulse_n), .skip(skip),
    .devData(devData), .devDrive(devDrive));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Command held until taken; page commands cover four bytes
  task automatic send(input op_e op, input logic [16:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk);
    cmd = '{op: op, addr: a, last: (op == OP_PAGE) ? a + 17'h0_0003 : a, data: d};
    cmdValid = 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (cmdReady !== 1'b1 && n < 20000);
    @(negedge clk) cmdValid = 1'b0;
    chk(busy, 32'h0000_0001);
  endtask
  // Wait for a result, judge it, then take it
  task automatic get(input logic [16:0] a, input logic [7:0] d, input logic f);
    int n;
    n = 0;
    while (resValid !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk(res.addr, a);
    chk(res.fail, f);
    if (!f) chk(res.data, d);
    resReady = 1'b1;
    @(negedge clk) resReady = 1'b0;
  endtask

  task automatic byte_then_read;
    send(OP_BYTE, 17'h0_0010, 32'h0000_005A);
    get(17'h0_0010, 8'h5A, 1'b0);
    chk(otp_device_model_i.mem[16], 8'h5A);
    send(OP_READ, 17'h0_0010, 32'h0000_0000);
    get(17'h0_0010, 8'h5A, 1'b0);
  endtask
  task automatic page_write;
    send(OP_PAGE, 17'h0_0020, 32'h4433_2211);
    get(17'h0_0020, 8'h44, 1'b0);
    for (int i = 0; i < 4; i++) chk(otp_device_model_i.mem[32 + i], 8'h11 * (i + 1));
    chk(otp_device_model_i.mem[36], 8'hFF);
  endtask
  task automatic top_and_refusal;
    send(OP_BYTE, ADDR_LAST, 32'h0000_00A5);
    get(ADDR_LAST, 8'hA5, 1'b0);
    send(OP_BYTE, 17'h0_F000, 32'h0000_0000);
    get(17'h0_F000, 8'h00, 1'b1);
    chk(otp_device_model_i.mem[61440], 8'hFF);
  endtask
  task automatic retries;
    skip = 4'h3;
    pulses = 0;
    send(OP_BYTE, 17'h0_0030, 32'h0000_003C);
    get(17'h0_0030, 8'h3C, 1'b0);
    chk(pulses, 4);
    skip = 4'hF;
    pulses = 0;
    send(OP_BYTE, 17'h0_0031, 32'h0000_00C3);
    get(17'h0_0031, 8'h00, 1'b1);
    chk(pulses, 10);
    skip = 4'h0;
  endtask
  // The first result waits in the buffer while the taker stalls until the second read is sent
  task automatic stalled_results;
    send(OP_READ, 17'h0_0021, 32'h0000_0000);
    send(OP_READ, 17'h0_0031, 32'h0000_0000);
    get(17'h0_0021, 8'h22, 1'b0);
    get(17'h0_0031, 8'hFF, 1'b0);
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    byte_then_read();
    page_write();
    top_and_refusal();
    retries();
    stalled_results();
    test_done();
  end
endmodule // prom_programmer_test
